// ===== rtl/rx_capture.sv
`timescale 1ns/1ps
`include "rx_capture_regs.svh"

module rx_capture #(
  parameter int                   DATA_W   = 8,
  parameter int                   LINK_MHZ = 250,
  parameter logic [`RX_DLY_W-1:0] ZH_DELAY = 8'h00
) (
  input  wire logic                  core_clk,
  input  wire logic                  core_ce,
  input  wire logic                  sys_rst,
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  link_clk,
  input  wire logic [DATA_W-1:0]     rx_data_pin,
  input  wire logic                  dll_lock,
  input  wire logic [`RX_DLY_W-1:0]  dll_code,
  output logic                       dll_freeze,
  output logic [7:0]                 dll_margin,
  output logic                       dll_margin_en,
  output logic [`RX_DLY_W-1:0]       del_code,
  output logic                       del_load,
  output logic                       clk_shift_en,
  output logic [`RX_DLY_W-1:0]       data_delay_code,
  output logic                       data_delay_dyn,
  output logic                       delay_type_out,
  output logic [2*DATA_W-1:0]        rx_word,
  output logic                       rx_valid
);

  localparam resp_okay = 2'h0;
  localparam resp_slverr = 2'h2;

  typedef struct packed {
    logic [31:0]         ctrl;
    logic [31:0]         dly;
    logic [31:0]         dyn;
    logic [31:0]         mrg;
    logic                awd;
    logic                wd;
    logic                bv;
    logic                rv;
    logic [7:0]          awa;
    logic [31:0]         wdat;
    logic [3:0]          wstb;
    logic [1:0]          bresp;
    logic [1:0]          rresp;
    logic [31:0]         rdat;
    logic [2*DATA_W-1:0] rx;
    logic [31:0]         cnt;
    logic                vld;
    logic                req_m;
    logic                req_s;
    logic                ack;
    logic                run_m;
    logic                run_s;
  } core_t;

  typedef struct packed {
    logic [2:0]                  cfg_m;
    logic [2:0]                  cfg_s;
    logic                        ack_m;
    logic                        ack_s;
    logic                        req;
    logic [2*DATA_W-1:0]         hold;
    logic [DATA_W-1:0]           rise;
    rx_capture_pkg::sync_st_t    st;
    logic [`RX_DLY_W-1:0]        code;
    logic                        load;
    logic                        thaw;
    logic                        run;
  } link_t;

  localparam core_t CORE_RST = '{
    ctrl:    `RX_CTRL_RST,
    dly:     `RX_DLY_RST,
    dyn:     `RX_DYN_RST,
    mrg:     `RX_MRG_RST,
    default: '0
  };

  core_t cq;
  core_t cd;
  link_t lq;
  link_t ld;
  logic [DATA_W-1:0] fall_q;
  rx_capture_pkg::mode_t mode;
  rx_capture_pkg::mode_t lk_mode;
  logic [2*DATA_W-1:0] word;
  logic aw_fire;
  logic w_fire;
  logic ar_fire;
  logic take;

  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] nw,
    input logic [3:0]  strb
  );
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  // ---------------- core domain: register slave
  assign mode = rx_capture_pkg::mode_t'(cq.ctrl[`RX_CTRL_MODE +: 2]);
  assign s_axi_awready = core_ce & ~cq.awd & ~cq.bv;
  assign s_axi_wready = core_ce & ~cq.wd & ~cq.bv;
  assign s_axi_arready = core_ce & ~cq.rv;
  assign aw_fire = s_axi_awvalid & s_axi_awready;
  assign w_fire = s_axi_wvalid & s_axi_wready;
  assign ar_fire = s_axi_arvalid & s_axi_arready;

  always_comb begin
    cd = cq;
    cd.vld = 1'b0;
    cd.req_m = lq.req;
    cd.req_s = cq.req_m;
    cd.run_m = lq.run;
    cd.run_s = cq.run_m;
    // snapshot is stable while the handshake is open
    if (cq.req_s != cq.ack) begin
      cd.rx = lq.hold;
      cd.ack = cq.req_s;
      cd.vld = 1'b1;
      cd.cnt = cq.cnt + 32'h0000_0001;
    end
    if (aw_fire) begin
      cd.awd = 1'b1;
      cd.awa = s_axi_awaddr;
    end
    if (w_fire) begin
      cd.wd = 1'b1;
      cd.wdat = s_axi_wdata;
      cd.wstb = s_axi_wstrb;
    end
    if (cq.bv && s_axi_bready) begin
      cd.bv = 1'b0;
    end
    if (cq.awd && cq.wd) begin
      cd.awd = 1'b0;
      cd.wd = 1'b0;
      cd.bv = 1'b1;
      cd.bresp = resp_okay;
      case (cq.awa)
        `RX_OFS_CTRL: begin
          cd.ctrl = merge(cq.ctrl, cq.wdat, cq.wstb) & `RX_CTRL_MASK;
        end
        `RX_OFS_DLY: begin
          cd.dly = merge(cq.dly, cq.wdat, cq.wstb) & `RX_DLY_MASK;
        end
        `RX_OFS_DYN: begin
          cd.dyn = merge(cq.dyn, cq.wdat, cq.wstb) & `RX_DLY_MASK;
        end
        `RX_OFS_MRG: begin
          cd.mrg = merge(cq.mrg, cq.wdat, cq.wstb) & `RX_MRG_MASK;
        end
        `RX_OFS_STAT, `RX_OFS_DATA, `RX_OFS_CNT: begin
          cd.bresp = resp_okay;
        end
        default: begin
          cd.bresp = resp_slverr;
        end
      endcase
    end
    if (cq.rv && s_axi_rready) begin
      cd.rv = 1'b0;
    end
    if (ar_fire) begin
      cd.rv = 1'b1;
      cd.rresp = resp_okay;
      case (s_axi_araddr)
        `RX_OFS_CTRL: cd.rdat = cq.ctrl;
        `RX_OFS_DLY:  cd.rdat = cq.dly;
        `RX_OFS_DYN:  cd.rdat = cq.dyn;
        `RX_OFS_MRG:  cd.rdat = cq.mrg;
        `RX_OFS_STAT: begin
          cd.rdat = '0;
          cd.rdat[`RX_STAT_LOCK] = cq.run_s;
          cd.rdat[`RX_STAT_SHIFT] = clk_shift_en;
        end
        `RX_OFS_DATA: cd.rdat = 32'(cq.rx);
        `RX_OFS_CNT:  cd.rdat = cq.cnt;
        default: begin
          cd.rdat = '0;
          cd.rresp = resp_slverr;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cq <= CORE_RST;
    end else if (core_ce) begin
      cq <= cd;
    end
  end

  assign s_axi_bvalid = cq.bv;
  assign s_axi_bresp = cq.bresp;
  assign s_axi_rvalid = cq.rv;
  assign s_axi_rdata = cq.rdat;
  assign s_axi_rresp = cq.rresp;
  assign rx_word = cq.rx;
  assign rx_valid = cq.vld;

  // dynamic value wins over either static setting
  assign data_delay_code = cq.ctrl[`RX_CTRL_DYN] ? cq.dyn[`RX_DLY_W-1:0] :
                           cq.ctrl[`RX_CTRL_TYPE] ? cq.dly[`RX_DLY_W-1:0] :
                           ZH_DELAY;
  assign data_delay_dyn = cq.ctrl[`RX_CTRL_DYN];
  assign delay_type_out = cq.ctrl[`RX_CTRL_TYPE];
  assign clk_shift_en = (mode == rx_capture_pkg::MODE_DDR_ALN);
  assign dll_margin = cq.mrg[7:0];
  assign dll_margin_en = cq.mrg[`RX_MRG_EN] & clk_shift_en;

  // ---------------- link domain: capture and delay-line sync
  always_ff @(negedge link_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fall_q <= '0;
    end else begin
      fall_q <= rx_data_pin;
    end
  end

  assign lk_mode = rx_capture_pkg::mode_t'(lq.cfg_s[2:1]);
  assign take = (lq.ack_s == lq.req);
  // rise half pairs with the falling sample that follows it
  assign word = (lk_mode == rx_capture_pkg::MODE_DDR_CTR ||
                 lk_mode == rx_capture_pkg::MODE_DDR_ALN) ?
                {fall_q, lq.rise} :
                {{DATA_W{1'b0}}, lq.cfg_s[0] ? fall_q : lq.rise};

  always_comb begin
    ld = lq;
    ld.cfg_m = cq.ctrl[2:0];
    ld.cfg_s = lq.cfg_m;
    ld.ack_m = cq.ack;
    ld.ack_s = lq.ack_m;
    ld.rise = rx_data_pin;
    if (take) begin
      ld.hold = word;
      ld.req = ~lq.req;
    end
    // delay line is clocked by its own output, as is the DLL
    case (lq.st)
      rx_capture_pkg::ST_HOLD: begin
        ld.thaw = 1'b0;
        ld.load = 1'b0;
        if (dll_lock) begin
          ld.st = rx_capture_pkg::ST_LOAD;
          ld.load = 1'b1;
          ld.code = dll_code;
        end
      end
      rx_capture_pkg::ST_LOAD: begin
        ld.st = rx_capture_pkg::ST_RUN;
        ld.thaw = 1'b1;
        ld.code = dll_code;
      end
      rx_capture_pkg::ST_RUN: begin
        if (!dll_lock) begin
          ld.st = rx_capture_pkg::ST_HOLD;
          ld.thaw = 1'b0;
          ld.load = 1'b0;
        end else begin
          ld.code = dll_code;
        end
      end
      default: begin
        ld.st = rx_capture_pkg::ST_HOLD;
        ld.thaw = 1'b0;
        ld.load = 1'b0;
      end
    endcase
    ld.run = (ld.st == rx_capture_pkg::ST_RUN);
  end

  always_ff @(posedge link_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lq <= '0;
    end else begin
      lq <= ld;
    end
  end

  assign dll_freeze = ~lq.thaw;
  assign del_code = lq.code;
  assign del_load = lq.load;

  // ---------------- checks
  property p_width;
    @(posedge core_clk) disable iff (sys_rst)
      1'b1 |-> (DATA_W <= `RX_MAX_WIDTH);
  endproperty
  a_width: assert property (p_width) else $error("data width too wide");

  property p_sdr_rate;
    @(posedge core_clk) disable iff (sys_rst)
      (mode == rx_capture_pkg::MODE_SDR) |-> (LINK_MHZ <= `RX_SDR_MAX_MHZ);
  endproperty
  a_sdr_rate: assert property (p_sdr_rate) else $error("sdr rate too high");

  property p_ddr_rate;
    @(posedge core_clk) disable iff (sys_rst)
      (mode != rx_capture_pkg::MODE_SDR) |-> (LINK_MHZ <= `RX_DDR_MAX_MHZ);
  endproperty
  a_ddr_rate: assert property (p_ddr_rate) else $error("ddr rate too high");

  property p_rise_cap;
    @(posedge link_clk) disable iff (sys_rst)
      1'b1 |=> (lq.rise == $past(rx_data_pin));
  endproperty
  a_rise_cap: assert property (p_rise_cap) else $error("rise sample wrong");

  property p_rst_clear;
    @(posedge core_clk)
      $fell(sys_rst) |-> (cq.rx == '0 && cq.cnt == 32'h0000_0000);
  endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("not cleared by reset");

  property p_inv_sdr;
    @(posedge link_clk) disable iff (sys_rst)
      (take && lq.cfg_s == 3'h1) |=> (lq.hold[DATA_W-1:0] == $past(fall_q));
  endproperty
  a_inv_sdr: assert property (p_inv_sdr) else $error("inverted sample wrong");

  property p_ddr_pair;
    @(posedge link_clk) disable iff (sys_rst)
      (take && lk_mode != rx_capture_pkg::MODE_SDR && lq.cfg_s[2:1] != 2'h3)
      |=> (lq.hold == {$past(fall_q), $past(lq.rise)});
  endproperty
  a_ddr_pair: assert property (p_ddr_pair) else $error("ddr pair wrong");

  property p_static_dly;
    @(posedge core_clk) disable iff (sys_rst)
      (!cq.ctrl[`RX_CTRL_DYN] && !cq.ctrl[`RX_CTRL_TYPE]) |-> (data_delay_code == ZH_DELAY);
  endproperty
  a_static_dly: assert property (p_static_dly) else $error("default delay wrong");

  property p_dyn_dly;
    @(posedge core_clk) disable iff (sys_rst)
      cq.ctrl[`RX_CTRL_DYN] |-> (data_delay_code == cq.dyn[`RX_DLY_W-1:0]);
  endproperty
  a_dyn_dly: assert property (p_dyn_dly) else $error("dynamic override lost");

  property p_shift;
    @(posedge core_clk) disable iff (sys_rst)
      (mode == rx_capture_pkg::MODE_DDR_CTR) |-> (!clk_shift_en && !dll_margin_en);
  endproperty
  a_shift: assert property (p_shift) else $error("centered clock shifted");

  property p_hold;
    @(posedge link_clk) disable iff (sys_rst)
      (lq.st == rx_capture_pkg::ST_HOLD) |-> (!del_load && dll_freeze);
  endproperty
  a_hold: assert property (p_hold) else $error("update before lock");

  property p_lock_seq;
    @(posedge link_clk) disable iff (sys_rst)
      (lq.st == rx_capture_pkg::ST_HOLD && dll_lock)
      |=> (del_load && dll_freeze && del_code == $past(dll_code)) ##1 !dll_freeze;
  endproperty
  a_lock_seq: assert property (p_lock_seq) else $error("lock order wrong");

  property p_track;
    @(posedge link_clk) disable iff (sys_rst)
      (lq.st == rx_capture_pkg::ST_RUN && dll_lock) |=> (del_code == $past(dll_code));
  endproperty
  a_track: assert property (p_track) else $error("code not tracked");

  c_ddr_word: cover property (@(posedge core_clk) disable iff (sys_rst)
    rx_valid && mode == rx_capture_pkg::MODE_DDR_ALN);
  c_locked: cover property (@(posedge link_clk) disable iff (sys_rst)
    $rose(lq.run));
  c_inv: cover property (@(posedge link_clk) disable iff (sys_rst)
    take && lq.cfg_s == 3'h1);
  c_slverr: cover property (@(posedge core_clk) disable iff (sys_rst)
    s_axi_bvalid && s_axi_bresp == resp_slverr);

endmodule : rx_capture

// ===== rtl/rx_capture_regs.svh
// Functional notes
// - SDR path samples each data bit on the capture clock's rising edge.
// - Capture register clears asynchronously on active-high reset.
// - Optional clock inversion makes SDR sampling use the opposite edge.
// - SDR receive path runs up to 300 MHz; transmitter stays within it.
// - Static delay is zero-hold default or a fixed user value.
// - Dynamic delay, when enabled, overrides the configured starting delay at run time.
// - Delay type attribute selects which delay value reaches the data path.
// - DDR x1 receive, centered or aligned, only up to 250 MHz.
// - Capture logic supports data bus widths up to 256 bits.
// - Centered mode: clock passes unshifted, only data is delayed.
// - Aligned mode: clock phase shifted by DLL-controlled delay line.
// - Delayed clock clocks the DLL; DLL code feeds the delay line.
// - Synchroniser blocks delay-line updates until DLL lock.
// - On lock: load delay line first, then release DLL freeze.
// - Optional margin input adjusts DLL delay in aligned mode.
`ifndef RX_CAPTURE_REGS_SVH
`define RX_CAPTURE_REGS_SVH

`define RX_OFS_CTRL   8'h00
`define RX_OFS_DLY    8'h04
`define RX_OFS_DYN    8'h08
`define RX_OFS_MRG    8'h0C
`define RX_OFS_STAT   8'h10
`define RX_OFS_DATA   8'h14
`define RX_OFS_CNT    8'h18

`define RX_CTRL_INV   0
`define RX_CTRL_MODE  1
`define RX_CTRL_DYN   3
`define RX_CTRL_TYPE  4
`define RX_MRG_EN     8
`define RX_STAT_LOCK  0
`define RX_STAT_SHIFT 1

`define RX_CTRL_MASK  32'h0000_001F
`define RX_DLY_MASK   32'h0000_00FF
`define RX_MRG_MASK   32'h0000_01FF

`define RX_CTRL_RST   32'h0000_0000
`define RX_DLY_RST    32'h0000_0000
`define RX_DYN_RST    32'h0000_0000
`define RX_MRG_RST    32'h0000_0000

`define RX_DLY_W      8
`define RX_MAX_WIDTH  256
`define RX_SDR_MAX_MHZ 300
`define RX_DDR_MAX_MHZ 250

`endif

// ===== rtl/rx_capture_pkg.sv
package rx_capture_pkg;
  typedef enum logic [1:0] {
    MODE_SDR,
    MODE_DDR_CTR,
    MODE_DDR_ALN
  } mode_t;

  typedef enum logic [1:0] {
    ST_HOLD,
    ST_LOAD,
    ST_RUN
  } sync_st_t;

  typedef logic [1:0] resp_t;
endpackage : rx_capture_pkg

// ===== testbench/link_tx_model.sv
`timescale 1ns/1ps

module link_tx_model #(
  parameter int DATA_W = 8
) (
  input  wire logic              run,
  input  wire logic [DATA_W-1:0] rise_v,
  input  wire logic [DATA_W-1:0] fall_v,
  output logic                   link_clk,
  output logic [DATA_W-1:0]      rx_data_pin
);
  // 48 ns period stays inside both rate limits
  initial begin
    link_clk = 1'b0;
    rx_data_pin = '0;
    #3.3;
    forever begin
      if (!run) begin
        // clock parked, data lines keep toggling so stale values never match
        #12 rx_data_pin = ~rx_data_pin;
      end else begin
        // each sample centred in its eye, edge straight onto the clock port
        #12 rx_data_pin = rise_v;
        #12 link_clk = 1'b1;
        #12 rx_data_pin = fall_v;
        #12 link_clk = 1'b0;
      end
    end
  end
endmodule : link_tx_model

// ===== testbench/tb_sdr_ddr_x1_input_capture.sv
`timescale 1ns/1ps
`include "rx_capture_regs.svh"

module tb_sdr_ddr_x1_input_capture;
  logic        core_clk, sys_rst, run, dll_lock, link_clk, rx_valid;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        freeze, mrg_en, del_load, shift_en, dly_dyn, dly_type;
  logic [7:0]  awaddr, araddr, dll_code, margin, del_code, dly_code, rx_data_pin;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [15:0] rx_word;
  logic        ce;
  logic [7:0]  rise_v, fall_v;
  int          n_mismatch, n_compared;

  rx_capture #(.DATA_W(8), .LINK_MHZ(21), .ZH_DELAY(8'h5A)) uut (
    .core_clk(core_clk), .core_ce(ce), .sys_rst(sys_rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .link_clk(link_clk),
    .rx_data_pin(rx_data_pin), .dll_lock(dll_lock), .dll_code(dll_code),
    .dll_freeze(freeze), .dll_margin(margin), .dll_margin_en(mrg_en),
    .del_code(del_code), .del_load(del_load), .clk_shift_en(shift_en),
    .data_delay_code(dly_code), .data_delay_dyn(dly_dyn),
    .delay_type_out(dly_type), .rx_word(rx_word), .rx_valid(rx_valid));

  link_tx_model #(.DATA_W(8)) tx (.run(run), .rise_v(rise_v), .fall_v(fall_v),
    .link_clk(link_clk), .rx_data_pin(rx_data_pin));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic aw_done, w_done, aw_hit, w_hit;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge core_clk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(negedge core_clk);
      aw_hit = awvalid && awready;
      w_hit  = wvalid && wready;
      @(posedge core_clk);
      if (aw_hit) awvalid <= 1'b0;
      if (w_hit) wvalid <= 1'b0;
      aw_done |= aw_hit;
      w_done |= w_hit;
    end while (!(aw_done && w_done));
    do @(negedge core_clk); while (bvalid !== 1'b1);
    chk(32'(bresp), 32'h0000_0000);
    @(posedge core_clk);
    bready <= 1'b0;
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge core_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(negedge core_clk); while (arready !== 1'b1);
    @(posedge core_clk);
    arvalid <= 1'b0;
    do @(negedge core_clk); while (rvalid !== 1'b1);
    chk(rdata, exp);
    chk(32'(rresp), 32'(er));
    @(posedge core_clk);
    rready <= 1'b0;
  endtask : rchk

  task automatic lk(input int n);
    repeat (n) @(negedge link_clk);
  endtask : lk

  task automatic wv;
    do @(negedge core_clk); while (rx_valid !== 1'b1);
  endtask : wv

  task automatic print_verdict;
    $display("Mismatches %0d, compares %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  initial begin
    #300000;
    n_mismatch++;
    print_verdict();
  end

  initial begin
    logic [31:0] ctl [5];
    logic [15:0] expw [5];
    logic [15:0] msk [5];
    logic [7:0]  ofs [4];
    ctl = '{32'h0, 32'h1, 32'h6, 32'h2, 32'h4};
    expw = '{16'h00C3, 16'h0096, 16'h00C3, 16'h96C3, 16'h96C3};
    msk = '{16'h00FF, 16'h00FF, 16'h00FF, 16'hFFFF, 16'hFFFF};
    ofs = '{`RX_OFS_CTRL, `RX_OFS_DLY, `RX_OFS_DYN, `RX_OFS_MRG};
    {sys_rst, run, dll_lock, dll_code, awaddr, araddr} = {1'b1, 1'b1, 1'b0, 24'h0};
    {awvalid, wvalid, bready, arvalid, rready, wdata, wstrb} = '0;
    {ce, rise_v, fall_v} = {1'b1, 8'hC3, 8'h96};
    n_mismatch = 0;
    n_compared = 0;
    repeat (3) @(posedge link_clk);
    chk(32'(freeze), 32'h1);
    chk(32'(del_load), 32'h0);
    chk(32'(rx_word), 32'h0);
    @(posedge core_clk);
    sys_rst <= 1'b0;
    foreach (ofs[i]) rchk(ofs[i], 32'h0, 2'h0);
    rchk(8'h40, 32'h0, 2'h2);
    @(negedge core_clk);
    chk(32'(dly_code), 32'h5A);
    wr(`RX_OFS_DLY, 32'h3C, 4'hF);
    wr(`RX_OFS_DLY, 32'hFF, 4'h0);
    wr(`RX_OFS_CTRL, 32'h10, 4'hF);
    chk(32'(dly_code), 32'h3C);
    chk(32'(dly_type), 32'h1);
    rchk(`RX_OFS_DLY, 32'h3C, 2'h0);
    // clock enable low: bus refused, settings frozen
    @(posedge core_clk);
    ce <= 1'b0;
    repeat (3) @(negedge core_clk);
    chk(32'({awready, wready, arready}), 32'h0);
    chk(32'(dly_code), 32'h3C);
    @(posedge core_clk);
    ce <= 1'b1;
    wr(`RX_OFS_DYN, 32'hA7, 4'hF);
    wr(`RX_OFS_CTRL, 32'h18, 4'hF);
    chk(32'(dly_code), 32'hA7);
    wr(`RX_OFS_CTRL, 32'h08, 4'hF);
    chk(32'(dly_code), 32'hA7);
    chk(32'(dly_dyn), 32'h1);
    wr(`RX_OFS_MRG, 32'h17E, 4'hF);
    wr(`RX_OFS_CTRL, 32'h2, 4'hF);
    chk(32'(shift_en), 32'h0);
    chk(32'(mrg_en), 32'h0);
    wr(`RX_OFS_CTRL, 32'h4, 4'hF);
    chk(32'(shift_en), 32'h1);
    chk({23'h0, mrg_en, margin}, 32'h17E);
    lk(4);
    chk(32'(freeze), 32'h1);
    chk(32'(del_load), 32'h0);
    @(posedge link_clk);
    dll_lock <= 1'b1;
    dll_code <= 8'h3C;
    for (int i = 0; i < 8 && del_load !== 1'b1; i++) @(negedge link_clk);
    chk({del_load, freeze, del_code}, {2'b11, 8'h3C});
    lk(1);
    chk(32'(freeze), 32'h0);
    @(posedge link_clk);
    dll_code <= 8'h41;
    lk(3);
    chk(32'(del_code), 32'h41);
    rchk(`RX_OFS_STAT, 32'h3, 2'h0);
    for (int i = 0; i < 5; i++) begin
      wr(`RX_OFS_CTRL, ctl[i], 4'hF);
      lk(4);
      wv();
      wv();
      chk(32'(rx_word & msk[i]), 32'(expw[i]));
    end
    rchk(`RX_OFS_DATA, 32'h96C3, 2'h0);
    @(posedge core_clk);
    fall_v <= 8'h69;
    lk(4);
    wv();
    wv();
    chk(32'(rx_word), 32'h69C3);
    @(posedge link_clk);
    dll_lock <= 1'b0;
    lk(3);
    chk(32'(freeze), 32'h1);
    @(posedge core_clk);
    sys_rst <= 1'b1;
    #1;
    chk(32'(rx_word), 32'h0);
    repeat (3) @(posedge link_clk);
    @(posedge core_clk);
    sys_rst <= 1'b0;
    rchk(`RX_OFS_CTRL, 32'h0, 2'h0);
    print_verdict();
  end
endmodule : tb_sdr_ddr_x1_input_capture
